//--- logic/lpcf_top.sv
// Control-CPU low-power clock gating, shared and analog clock derivation, missing-clock detection.
// Assumes one 250 MHz clock; all derived clocks are one-cycle enables. Pins are asynchronous.
//
// Overview of operation
// R1 - Idle stops core clock, system clock runs
// R2 - Idle exits on enabled interrupt or NMI
// R3 - Idle exit restores core clock, optional wake handler
// R4 - Standby stops input, core, system clocks
// R5 - Standby exits on selected pin or IPC1
// R6 - Wake pin qualified by qualify field first
// R7 - Standby exit restores clocks, optional wake handler
// R8 - Master parks control CPU before deep sleep
// R9 - Deep sleep with standby wakes from master
// R10 - Analog clock divided; register control-CPU-only writable
// R11 - Analog reset restores analog clock register
// R12 - Analog clock stops in master deep sleep
// R13 - Shared logic on PLL clock, interface master
// R14 - PLL clock from PLL or oscillator, divided
// R15 - Missing clock switches to internal 10 MHz
// R16 - Detector runs from internal 10 MHz clock
// R17 - Clock loss flags NMIs, PWMs, mux immediately
// R18 - NMI raised and watchdog started together
// R19 - Watchdog overflow resets unless software disables
// R20 - PWMs get clock loss to stop outputs
// R21 - Only main clock is watched, not auxiliary
// R22 - Halt plus select bits choose mode
// R23 - Deep sleep stops control and shared input clocks
// R24 - Cross-domain flags synchronised before use
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module lpcf_top #(
  parameter int NMIWD_CYCLES = lpcf_pkg::NMIWD_DEFAULT
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [lpcf_pkg::ADDR_W-1:0]   addr,
  input  wire logic [lpcf_pkg::DATA_W-1:0]   wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  input  wire logic                          wr_from_ctrl,
  output logic      [lpcf_pkg::DATA_W-1:0]   rdata,
  input  wire logic                          halt_indication,
  input  wire logic                          any_enabled_irq,
  input  wire logic [lpcf_pkg::WAKE_PINS-1:0] wake_pins,
  input  wire logic                          master_to_ctrl_ipc_irq1,
  input  wire logic                          master_deep_sleep,
  input  wire logic                          analog_bus_reset,
  input  wire logic                          analog_subsystem_reset,
  input  wire logic                          oscillator_clock,
  input  wire logic                          internal_ten_meg_clock,
  input  wire logic                          main_pll_tick,
  input  wire logic                          master_subsystem_clock_tick,
  input  wire logic                          master_nmiwd_disable,
  output logic                               core_clock_en,
  output logic                               ctrl_system_clock_en,
  output logic                               ctrl_input_clock_en,
  output logic                               resume_fetch,
  output logic                               standby_wake_irq,
  output logic                               pll_system_clock_tick,
  output logic                               shared_clock_tick,
  output logic                               analog_system_clock_tick,
  output logic                               epi_clock_tick,
  output logic                               clock_loss_flag,
  output logic                               ctrl_nmi_interrupt,
  output logic                               master_nmi_interrupt,
  output logic                               pwm_trip,
  output logic                               device_reset_req,
  output logic      [lpcf_pkg::LPST_W-1:0]   ctrl_lowpower_status
);

  // Asynchronous inputs gathered for a two-stage synchroniser.
  localparam int NA = lpcf_pkg::WAKE_PINS + 6;
  logic [NA-1:0] ain;
  logic [NA-1:0] s1_r;
  logic [NA-1:0] s2_r;
  assign ain = {wake_pins, master_to_ctrl_ipc_irq1, master_deep_sleep, analog_bus_reset,
                analog_subsystem_reset, oscillator_clock, internal_ten_meg_clock};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= ain; // R24
      s2_r <= s1_r;
    end
  end

  wire [lpcf_pkg::WAKE_PINS-1:0] pins_s = s2_r[NA-1:6];
  wire ipc1_s   = s2_r[5];
  wire dsleep_s = s2_r[4];
  wire arst_s   = s2_r[3] | s2_r[2]; // R11
  wire osc_s    = s2_r[1];
  wire tmeg_s   = s2_r[0];

  logic osc_d_r;
  logic tmeg_d_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_d_r  <= 1'b0;
      tmeg_d_r <= 1'b0;
    end else begin
      osc_d_r  <= osc_s;
      tmeg_d_r <= tmeg_s;
    end
  end
  wire osc_tick  = osc_s & ~osc_d_r;
  wire tmeg_tick = tmeg_s & ~tmeg_d_r;

  // Registers.
  logic [lpcf_pkg::LPS_W-1:0]  lps_r;
  logic [lpcf_pkg::QUAL_W-1:0] qual_r;
  logic                        wirq_en_r;
  logic [lpcf_pkg::ADIV_W-1:0] adiv_r;
  logic [lpcf_pkg::SDIV_W-1:0] sdiv_r;
  logic                        bypass_r;
  logic [lpcf_pkg::WSEL_W-1:0] wsel_r;
  logic                        ctrl_wd_dis_r;
  logic [lpcf_pkg::LPST_W-1:0] lpstat_r;

  wire wr_pc0  = wr & (addr == lpcf_pkg::OFF_PCLKCTL0);
  wire wr_acl  = wr & (addr == lpcf_pkg::OFF_ACLKCTL) & wr_from_ctrl; // R10
  wire wr_sdv  = wr & (addr == lpcf_pkg::OFF_SYSDIV);
  wire wr_wsl  = wr & (addr == lpcf_pkg::OFF_WAKESEL);
  wire wr_wd   = wr & (addr == lpcf_pkg::OFF_NMIWD);
  wire wr_lps  = wr & (addr == lpcf_pkg::OFF_LPSTAT);
  // Only 62 pins can be selected by the mux; larger indices are clamped to WSEL_MAX.
  wire [lpcf_pkg::WSEL_W-1:0] wsel_in = (wdata[lpcf_pkg::WSEL_W-1:0] > lpcf_pkg::WSEL_MAX) ?
                                        lpcf_pkg::WSEL_MAX : wdata[lpcf_pkg::WSEL_W-1:0]; // R5

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lps_r     <= lpcf_pkg::LPS_RST;
      qual_r    <= lpcf_pkg::QUAL_RST;
      wirq_en_r <= 1'b0;
      sdiv_r    <= lpcf_pkg::SDIV_RST;
      bypass_r  <= 1'b0;
      wsel_r    <= '0;
      lpstat_r  <= '0;
    end else begin
      if (wr_pc0) begin
        lps_r     <= wdata[lpcf_pkg::LPS_LSB +: lpcf_pkg::LPS_W];
        qual_r    <= wdata[lpcf_pkg::QUAL_LSB +: lpcf_pkg::QUAL_W];
        wirq_en_r <= wdata[lpcf_pkg::WIRQ_BIT];
      end
      if (wr_sdv) begin
        sdiv_r   <= wdata[lpcf_pkg::SDIV_W-1:0];
        bypass_r <= wdata[lpcf_pkg::BYP_BIT];
      end
      if (wr_wsl) wsel_r <= wsel_in;
      if (wr_lps) lpstat_r <= wdata[lpcf_pkg::LPST_W-1:0]; // R8
    end
  end

  // The analog reset acts synchronously so that a glitch on it cannot corrupt the divider.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adiv_r <= lpcf_pkg::ADIV_RST;
    end else if (arst_s) begin
      adiv_r <= lpcf_pkg::ADIV_RST; // R11
    end else if (wr_acl) begin
      adiv_r <= wdata[lpcf_pkg::ADIV_W-1:0]; // R10
    end
  end

  // Mode machine.
  lpcf_pkg::lpcf_mode_t mode_r;
  lpcf_pkg::lpcf_mode_t mode_nxt;
  logic                 qual_wake;
  logic                 resume_nxt;
  logic                 wirq_nxt;

  wire idle_exit    = any_enabled_irq | ctrl_nmi_interrupt; // R2
  // With the master in deep sleep the control system and input clocks are off, so a pin cannot wake us.
  wire standby_exit = ipc1_s | (qual_wake & ~dsleep_s); // R5 R9

  always_comb begin
    mode_nxt   = mode_r;
    resume_nxt = 1'b0;
    wirq_nxt   = 1'b0;
    case (mode_r)
      lpcf_pkg::LPCF_RUN: begin
        if (halt_indication) begin
          mode_nxt = (lps_r == lpcf_pkg::LPS_STANDBY) ? lpcf_pkg::LPCF_STANDBY : lpcf_pkg::LPCF_IDLE; // R22
        end
      end
      lpcf_pkg::LPCF_IDLE: begin
        if (idle_exit) begin
          mode_nxt   = lpcf_pkg::LPCF_RUN; // R3
          resume_nxt = 1'b1;
          wirq_nxt   = wirq_en_r;
        end
      end
      lpcf_pkg::LPCF_STANDBY: begin
        if (standby_exit) begin
          mode_nxt   = lpcf_pkg::LPCF_RUN; // R7
          resume_nxt = 1'b1;
          wirq_nxt   = wirq_en_r;
        end
      end
      default: mode_nxt = lpcf_pkg::LPCF_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r           <= lpcf_pkg::LPCF_RUN;
      resume_fetch     <= 1'b0;
      standby_wake_irq <= 1'b0;
    end else begin
      mode_r           <= mode_nxt;
      resume_fetch     <= resume_nxt;
      standby_wake_irq <= wirq_nxt;
    end
  end

  // Clock gates follow the next mode so that they change in the same cycle as the state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_clock_en        <= 1'b1;
      ctrl_system_clock_en <= 1'b1;
      ctrl_input_clock_en  <= 1'b1;
    end else begin
      core_clock_en        <= (mode_nxt == lpcf_pkg::LPCF_RUN); // R1 R4
      ctrl_system_clock_en <= (mode_nxt != lpcf_pkg::LPCF_STANDBY) & ~dsleep_s; // R1 R4 R23
      ctrl_input_clock_en  <= (mode_nxt != lpcf_pkg::LPCF_STANDBY) & ~dsleep_s; // R4 R23
    end
  end

  // Wake qualification: the selected pin must stay high for QUAL_BASE plus the programmed number of oscillator samples.
  logic [lpcf_pkg::QUAL_W:0] qcnt_r;
  wire                       wake_sel = pins_s[wsel_r];
  wire [lpcf_pkg::QUAL_W:0]  qlen     = lpcf_pkg::QUAL_BASE + {1'b0, qual_r};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qcnt_r    <= '0;
      qual_wake <= 1'b0;
    end else if (!wake_sel) begin
      qcnt_r    <= '0;
      qual_wake <= 1'b0;
    end else if (osc_tick && qcnt_r != qlen) begin
      qcnt_r    <= qcnt_r + 1'b1; // R6
      qual_wake <= (qcnt_r + 1'b1 == qlen);
    end
  end

  // Missing-clock detector on the oscillator clock, timed by the internal 10 MHz clock. The auxiliary clock has none.
  logic [7:0] miss_cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      miss_cnt_r      <= '0;
      clock_loss_flag <= 1'b0;
    end else begin
      if (osc_tick) begin
        miss_cnt_r <= '0; // R16 R21
      end else if (tmeg_tick && miss_cnt_r != lpcf_pkg::MISS_LIMIT) begin
        miss_cnt_r <= miss_cnt_r + 8'h01;
      end
      // The flag is sticky: a returning clock after a loss is not trusted until reset.
      if (tmeg_tick && miss_cnt_r + 8'h01 == lpcf_pkg::MISS_LIMIT) begin
        clock_loss_flag <= 1'b1; // R17
      end
    end
  end

  logic loss_d_r;
  wire  loss_rise = clock_loss_flag & ~loss_d_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loss_d_r             <= 1'b0;
      ctrl_nmi_interrupt   <= 1'b0;
      master_nmi_interrupt <= 1'b0;
      pwm_trip             <= 1'b0;
    end else begin
      loss_d_r             <= clock_loss_flag;
      ctrl_nmi_interrupt   <= loss_rise; // R17 R18
      master_nmi_interrupt <= loss_rise; // R17 R18
      pwm_trip             <= clock_loss_flag; // R20
    end
  end

  // NMI watchdogs, one per CPU, started by the same edge that raises the NMI.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ctrl_wd_dis_r <= 1'b0;
    else if (wr_wd && wdata[0]) ctrl_wd_dis_r <= 1'b1; // R19
  end

  wire [1:0] wd_dis = {master_nmiwd_disable, ctrl_wd_dis_r};
  logic [1:0] wd_ovf;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_wd
      logic        run_r;
      logic [31:0] cnt_r;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          run_r <= 1'b0;
          cnt_r <= '0;
        end else if (wd_dis[g]) begin
          run_r <= 1'b0; // R19
        end else if (loss_rise) begin
          run_r <= 1'b1; // R18
          cnt_r <= '0;
        end else if (run_r && tmeg_tick && cnt_r != 32'(NMIWD_CYCLES)) begin
          cnt_r <= cnt_r + 32'h0000_0001;
        end
      end
      assign wd_ovf[g] = run_r & (cnt_r == 32'(NMIWD_CYCLES));
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) device_reset_req <= 1'b0;
    else device_reset_req <= |wd_ovf; // R19
  end

  // PLL system clock: source mux then divide by select plus one.
  wire src_tick = clock_loss_flag ? tmeg_tick : (bypass_r ? osc_tick : main_pll_tick); // R14 R15
  logic [lpcf_pkg::SDIV_W-1:0] sdcnt_r;
  wire  sd_hit = src_tick & (sdcnt_r >= sdiv_r);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdcnt_r               <= '0;
      pll_system_clock_tick <= 1'b0;
    end else begin
      if (sd_hit) sdcnt_r <= '0;
      else if (src_tick) sdcnt_r <= sdcnt_r + 1'b1;
      pll_system_clock_tick <= sd_hit; // R14
    end
  end

  // Analog clock: PLL system clock divided by divider plus one, stopped in deep sleep.
  logic [lpcf_pkg::ADIV_W-1:0] adcnt_r;
  wire  ad_hit = pll_system_clock_tick & (adcnt_r >= adiv_r);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adcnt_r                  <= '0;
      analog_system_clock_tick <= 1'b0;
      shared_clock_tick        <= 1'b0;
      epi_clock_tick           <= 1'b0;
    end else begin
      if (ad_hit) adcnt_r <= '0;
      else if (pll_system_clock_tick) adcnt_r <= adcnt_r + 1'b1;
      analog_system_clock_tick <= ad_hit & ~dsleep_s; // R10 R12
      shared_clock_tick        <= pll_system_clock_tick & ~dsleep_s; // R13 R23
      epi_clock_tick           <= master_subsystem_clock_tick; // R13
    end
  end

  assign ctrl_lowpower_status = lpstat_r; // R8

  // Read mux; unmapped addresses read zero.
  logic [lpcf_pkg::DATA_W-1:0] rmux;
  always_comb begin
    rmux = '0;
    case (addr)
      lpcf_pkg::OFF_PCLKCTL0: rmux = 32'({wirq_en_r, qual_r, lps_r});
      lpcf_pkg::OFF_ACLKCTL:  rmux = 32'(adiv_r);
      lpcf_pkg::OFF_SYSDIV:   rmux = 32'({bypass_r, 2'h0, sdiv_r});
      lpcf_pkg::OFF_WAKESEL:  rmux = 32'(wsel_r);
      lpcf_pkg::OFF_NMIWD:    rmux = 32'({wd_ovf, ctrl_wd_dis_r});
      lpcf_pkg::OFF_STATUS:   rmux = 32'({dsleep_s, qual_wake, clock_loss_flag, mode_r});
      lpcf_pkg::OFF_LPSTAT:   rmux = 32'(lpstat_r);
      default:                rmux = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata <= '0;
    else if (rd) rdata <= rmux;
  end

endmodule // lpcf_top

`default_nettype wire

//--- logic/lpcf_pkg.sv
// Constants for the low-power, clock derivation and clock-loss block.
// Assumes a 250 MHz system clock and a plain single-cycle register port.
package lpcf_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_PCLKCTL0  = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_ACLKCTL   = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_SYSDIV    = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_WAKESEL   = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_NMIWD     = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_LPSTAT    = 5'h18;

  // periph_clock_ctrl0 fields.
  localparam int LPS_LSB  = 0;
  localparam int LPS_W    = 2;
  localparam int QUAL_LSB = 2;
  localparam int QUAL_W   = 6;
  localparam int WIRQ_BIT = 8;

  // Other field layouts.
  localparam int ADIV_W   = 3;
  localparam int SDIV_W   = 6;
  localparam int BYP_BIT  = 8;
  localparam int WSEL_W   = 6;
  localparam int LPST_W   = 8;

  // Reset values.
  localparam logic [ADIV_W-1:0] ADIV_RST = 3'h0;
  localparam logic [SDIV_W-1:0] SDIV_RST = 6'h00;
  localparam logic [QUAL_W-1:0] QUAL_RST = 6'h00;
  localparam logic [LPS_W-1:0]  LPS_RST  = 2'h0;

  // Low-power select codes.
  localparam logic [LPS_W-1:0] LPS_IDLE    = 2'h0;
  localparam logic [LPS_W-1:0] LPS_STANDBY = 2'h1;

  // Wake pins: 64 inputs, 62 of them may be selected.
  localparam int WAKE_PINS  = 64;
  localparam logic [WSEL_W-1:0] WSEL_MAX = 6'h3D;

  // Qualification length is QUAL_BASE plus the field, in oscillator periods.
  localparam logic [QUAL_W:0] QUAL_BASE = 7'h02;

  // Missing-clock window, counted in internal 10 MHz periods.
  localparam logic [7:0] MISS_LIMIT = 8'h08;

  // NMI watchdog length in 10 MHz periods (kept short; a top parameter overrides).
  localparam int NMIWD_DEFAULT = 65535;

  typedef enum logic [1:0] {
    LPCF_RUN,
    LPCF_IDLE,
    LPCF_STANDBY
  } lpcf_mode_t;

endpackage

//--- testbench/lpcf_properties.sv
// Port-level checks for the low-power, clock derivation and clock-loss block.
// Assumes one clock domain and the active-high asynchronous reset of the top module.
`timescale 1ns/1ps
`default_nettype none

module lpcf_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic halt_indication,
  input wire logic any_enabled_irq,
  input wire logic master_to_ctrl_ipc_irq1,
  input wire logic master_deep_sleep,
  input wire logic core_clock_en,
  input wire logic ctrl_system_clock_en,
  input wire logic ctrl_input_clock_en,
  input wire logic resume_fetch,
  input wire logic standby_wake_irq,
  input wire logic analog_system_clock_tick,
  input wire logic clock_loss_flag,
  input wire logic ctrl_nmi_interrupt,
  input wire logic master_nmi_interrupt,
  input wire logic pwm_trip,
  input wire logic device_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_halt_core;
    halt_indication && core_clock_en && ctrl_system_clock_en |=> !core_clock_en;
  endproperty
  a_halt_core: assert property (p_halt_core) else $error("core clock ran after halt");

  property p_standby_all;
    !ctrl_system_clock_en |-> !core_clock_en && !ctrl_input_clock_en;
  endproperty
  a_standby_all: assert property (p_standby_all) else $error("standby left a clock running");

  property p_idle_exit;
    !core_clock_en && ctrl_system_clock_en && (any_enabled_irq || ctrl_nmi_interrupt) |=> core_clock_en && resume_fetch;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left on interrupt");

  property p_standby_exit;
    $rose(ctrl_system_clock_en) |-> core_clock_en && ctrl_input_clock_en && resume_fetch;
  endproperty
  a_standby_exit: assert property (p_standby_exit) else $error("standby exit left clocks off");

  property p_wake_irq;
    standby_wake_irq |-> resume_fetch;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wake irq outside an exit");

  property p_deep_hold;
    (!ctrl_system_clock_en && master_deep_sleep && !master_to_ctrl_ipc_irq1) [*4] |=> !ctrl_system_clock_en;
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("standby left in deep sleep");

  property p_analog_off;
    master_deep_sleep [*4] |-> !analog_system_clock_tick;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog clock ticks in deep sleep");

  property p_loss_fanout;
    $rose(clock_loss_flag) |=> pwm_trip && ctrl_nmi_interrupt && master_nmi_interrupt;
  endproperty
  a_loss_fanout: assert property (p_loss_fanout) else $error("clock loss not passed on");

  property p_nmi_cause;
    ctrl_nmi_interrupt || master_nmi_interrupt |-> clock_loss_flag ##1 !ctrl_nmi_interrupt && !master_nmi_interrupt;
  endproperty
  a_nmi_cause: assert property (p_nmi_cause) else $error("nmi without loss or too long");

  property p_reset_cause;
    !clock_loss_flag |-> !device_reset_req;
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("device reset without clock loss");
endmodule // lpcf_properties

bind lpcf_top lpcf_properties chk (.*);

`default_nettype wire

//--- testbench/lpcf_master_model.sv
// Behavioural model of the master CPU facing the control-side clock block.
// Assumes the block's clock and reset; the testbench commands sleep and wake.
`timescale 1ns/1ps
`default_nettype none

module lpcf_master_model (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [lpcf_pkg::LPST_W-1:0] ctrl_lowpower_status,
  input  wire logic                        master_nmi_interrupt,
  input  wire logic                        sleep_req,
  input  wire logic                        wake_req,
  input  wire logic                        wd_respond,
  output logic                             master_deep_sleep,
  output logic                             master_to_ctrl_ipc_irq1,
  output logic                             master_nmiwd_disable
);
  logic deep_r;
  logic ipc_r;
  logic dis_r;

  // Deep sleep waits for the posted status so control clocks never vanish unannounced.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      deep_r <= 1'h0;
      ipc_r  <= 1'h0;
      dis_r  <= 1'h0;
    end else begin
      deep_r <= deep_r ? !wake_req : (sleep_req && ctrl_lowpower_status != 8'h00);
      ipc_r  <= wake_req;
      dis_r  <= dis_r || (master_nmi_interrupt && wd_respond);
    end
  end

  assign master_deep_sleep       = deep_r;
  assign master_to_ctrl_ipc_irq1 = ipc_r;
  assign master_nmiwd_disable    = dis_r;
endmodule // lpcf_master_model

`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the low-power and clock-loss block with a master CPU model.
// Assumes a 250 MHz clock; oscillator and 10 MHz pins are free-running and unrelated in phase.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                          clk, rst, wr, rd, wr_from_ctrl, halt_indication, any_enabled_irq;
  logic                          master_to_ctrl_ipc_irq1, master_deep_sleep, analog_bus_reset;
  logic                          analog_subsystem_reset, oscillator_clock, internal_ten_meg_clock;
  logic                          main_pll_tick, master_subsystem_clock_tick, master_nmiwd_disable;
  logic                          core_clock_en, ctrl_system_clock_en, ctrl_input_clock_en, resume_fetch;
  logic                          standby_wake_irq, pll_system_clock_tick, shared_clock_tick, epi_clock_tick;
  logic                          analog_system_clock_tick, clock_loss_flag, ctrl_nmi_interrupt, pwm_trip;
  logic                          master_nmi_interrupt, device_reset_req, osc_on, sleep_req, wake_req, wd_respond;
  logic [lpcf_pkg::ADDR_W-1:0]   addr;
  logic [lpcf_pkg::DATA_W-1:0]   wdata, rdata;
  logic [lpcf_pkg::WAKE_PINS-1:0] wake_pins;
  logic [lpcf_pkg::LPST_W-1:0]   ctrl_lowpower_status;
  logic [2:0]                    ev;
  logic [3:0]                    tk;
  int                            n_fail, checks, cyc, k, cnt[4];

  // Short watchdog so an overflow fits the run.
  lpcf_top #(.NMIWD_CYCLES(20)) uut (.*);
  lpcf_master_model master (.*);

  assign ev = {device_reset_req, clock_loss_flag, ctrl_system_clock_en};
  assign tk = {epi_clock_tick, analog_system_clock_tick, shared_clock_tick, pll_system_clock_tick};

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    internal_ten_meg_clock = 1'h0;
    #3;
    forever #50 internal_ten_meg_clock = ~internal_ten_meg_clock;
  end
  // A failed source freezes at its last level instead of toggling.
  always #20 if (osc_on) oscillator_clock = ~oscillator_clock;
  always @(posedge clk) master_subsystem_clock_tick <= ~master_subsystem_clock_tick;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [lpcf_pkg::ADDR_W-1:0] a, input logic [lpcf_pkg::DATA_W-1:0] d,
                        input logic ctl);
    @(posedge clk);
    {addr, wdata, wr, wr_from_ctrl} <= {a, d, 1'h1, ctl};
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_chk(input logic [lpcf_pkg::ADDR_W-1:0] a, input logic [lpcf_pkg::DATA_W-1:0] exp,
                        input string what);
    @(posedge clk);
    {addr, rd} <= {a, 1'h1};
    @(posedge clk);
    rd <= 1'h0;
    #1;
    check(what, rdata, exp);
  endtask
  task automatic pulse(input int irq);
    @(posedge clk);
    if (irq != 0) any_enabled_irq <= 1'h1;
    else halt_indication <= 1'h1;
    @(posedge clk);
    {halt_indication, any_enabled_irq} <= 2'h0;
    #1;
  endtask
  task automatic wait_ev(input int which, input int lim);
    repeat (lim) begin
      @(posedge clk);
      #1;
      if (ev[which] === 1'h1) break;
    end
  endtask
  task automatic count_ticks(input int n);
    repeat (40) @(posedge clk);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge clk);
      #1;
      foreach (cnt[j]) cnt[j] += tk[j];
    end
  endtask
  task final_report;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {rst, osc_on, main_pll_tick, oscillator_clock, master_subsystem_clock_tick} = 5'h1C;
    {wr, rd, wr_from_ctrl, halt_indication, any_enabled_irq, analog_bus_reset} = 6'h00;
    {analog_subsystem_reset, sleep_req, wake_req, wd_respond, addr, wdata, wake_pins} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rd_chk(lpcf_pkg::OFF_PCLKCTL0, 4'h0, "pclkctl0 reset");
    rd_chk(5'h1C, 4'h0, "unmapped");
    wr_reg(lpcf_pkg::OFF_ACLKCTL, 4'h3, 1'h0);
    rd_chk(lpcf_pkg::OFF_ACLKCTL, 4'h0, "aclk foreign write");
    for (k = 0; k < 2; k++) begin
      wr_reg(lpcf_pkg::OFF_ACLKCTL, 4'h5, 1'h1);
      rd_chk(lpcf_pkg::OFF_ACLKCTL, 4'h5, "aclk written");
      {analog_bus_reset, analog_subsystem_reset} <= (k == 0) ? 2'h2 : 2'h1;
      repeat (4) @(posedge clk);
      {analog_bus_reset, analog_subsystem_reset} <= 2'h0;
      repeat (4) @(posedge clk);
      rd_chk(lpcf_pkg::OFF_ACLKCTL, 4'h0, "aclk after analog reset");
    end
    wr_reg(lpcf_pkg::OFF_WAKESEL, 8'h3F, 1'h1);
    rd_chk(lpcf_pkg::OFF_WAKESEL, 8'h3D, "wake select limit");
    wr_reg(lpcf_pkg::OFF_WAKESEL, 4'h5, 1'h1);
    wr_reg(lpcf_pkg::OFF_ACLKCTL, 4'h1, 1'h1);
    wr_reg(lpcf_pkg::OFF_SYSDIV, 4'h2, 1'h1);
    count_ticks(60);
    check("pll ticks", cnt[0], 8'h14);
    check("shared ticks", cnt[1], 8'h14);
    check("analog ticks", cnt[2], 8'h0A);
    check("epi ticks", cnt[3], 8'h1E);
    wr_reg(lpcf_pkg::OFF_SYSDIV, 12'h102, 1'h1);
    count_ticks(60);
    check("bypass ticks", cnt[0], 8'h02);
    wr_reg(lpcf_pkg::OFF_SYSDIV, 4'h2, 1'h1);
    for (k = 0; k < 4; k++) begin
      if (k == 1) continue;
      wr_reg(lpcf_pkg::OFF_PCLKCTL0, (k == 3) ? 12'h103 : 12'(k), 1'h1);
      pulse(0);
      repeat (5) @(posedge clk);
      #1;
      check("idle enables", {core_clock_en, ctrl_system_clock_en, ctrl_input_clock_en}, 3'h3);
      pulse(1);
      check("idle exit", {core_clock_en, resume_fetch, standby_wake_irq}, (k == 3) ? 3'h7 : 3'h6);
    end
    wr_reg(lpcf_pkg::OFF_PCLKCTL0, 12'h101, 1'h1);
    pulse(0);
    check("standby enables", {core_clock_en, ctrl_system_clock_en, ctrl_input_clock_en}, 3'h0);
    wake_req <= 1'h1;
    wait_ev(0, 10);
    check("ipc wake", {core_clock_en, ctrl_input_clock_en, resume_fetch, standby_wake_irq}, 4'hF);
    wake_req <= 1'h0;
    wr_reg(lpcf_pkg::OFF_PCLKCTL0, 12'h10D, 1'h1);
    pulse(0);
    wake_pins <= 64'h40;
    repeat (100) @(posedge clk);
    wake_pins <= 64'h20;
    repeat (30) @(posedge clk);
    #1;
    check("unqualified pin", ctrl_system_clock_en, 1'h0);
    wait_ev(0, 200);
    check("pin wake", {ctrl_system_clock_en, resume_fetch, standby_wake_irq}, 3'h7);
    wake_pins <= 64'h0;
    wr_reg(lpcf_pkg::OFF_LPSTAT, 4'h1, 1'h1);
    wr_reg(lpcf_pkg::OFF_PCLKCTL0, 12'h101, 1'h1);
    check("status to master", ctrl_lowpower_status, 8'h01);
    pulse(0);
    {sleep_req, wake_pins} <= {1'h1, 64'h20};
    count_ticks(200);
    check("analog in deep sleep", cnt[2], 4'h0);
    check("held in standby", {master_deep_sleep, ctrl_system_clock_en}, 2'h2);
    {sleep_req, wake_req} <= 2'h1;
    wait_ev(0, 10);
    check("master wake", {ctrl_system_clock_en, resume_fetch}, 2'h3);
    {wake_pins, wake_req} <= '0;
    wr_reg(lpcf_pkg::OFF_NMIWD, 4'h1, 1'h1);
    {osc_on, main_pll_tick, wd_respond} <= 3'h1;
    wait_ev(1, 400);
    count_ticks(300);
    check("loss outputs", {clock_loss_flag, pwm_trip, cnt[0] != 0}, 3'h7);
    repeat (700) @(posedge clk);
    #1;
    check("no reset when disabled", device_reset_req, 1'h0);
    rd_chk(lpcf_pkg::OFF_STATUS, 4'h4, "status after loss");
    rd_chk(lpcf_pkg::OFF_NMIWD, 4'h1, "watchdog disabled");
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    {rst, wd_respond} <= 2'h0;
    wait_ev(2, 1400);
    check("watchdog reset", device_reset_req, 1'h1);
    rd_chk(lpcf_pkg::OFF_NMIWD, 4'h6, "watchdog overflow");
    final_report;
  end
endmodule // tb

`default_nettype wire
